// [hw/crsi_pkg.sv]
// Purpose: Shared constants and carrier types for the clock ready status block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: Offsets are local choices since none are printed
package crsi_pkg;
  // Register byte offsets
  localparam logic [7:0] CRSI_OFF_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] CRSI_OFF_IRQ_DISABLE = 8'h04;
  localparam logic [7:0] CRSI_OFF_IRQ_MASK_VIEW = 8'h08;
  localparam logic [7:0] CRSI_OFF_CLOCK_STATUS = 8'h0c;
  localparam logic [7:0] CRSI_OFF_WAKEUP_ENABLE = 8'h10;
  localparam logic [7:0] CRSI_OFF_PLL_CONFIG = 8'h14;
  // Field positions
  localparam int CRSI_BIT_MAIN = 0;
  localparam int CRSI_BIT_LOCK = 1;
  localparam int CRSI_BIT_MCK = 3;
  localparam int CRSI_BIT_PCK0 = 8;
  localparam int CRSI_BIT_SELS = 16;
  localparam int CRSI_PLL_CNT_LSB = 8;
  localparam int CRSI_PLL_CNT_W = 6;
  localparam int CRSI_NUM_PCK = 3;
  localparam int CRSI_NUM_WAKE = 16;
  // Defined interrupt source bits
  localparam logic [31:0] CRSI_IRQ_BITS = 32'h0000_070b;
  // Reset values
  localparam logic [31:0] CRSI_RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] CRSI_RST_WAKE = 16'h0000;
  // Slow clock cycles per unit of the settle count
  localparam int CRSI_SETTLE_MULT = 8;
  localparam int CRSI_SETTLE_W = CRSI_PLL_CNT_W + 3;

  // Raw readiness inputs as one carrier
  typedef struct packed {
    logic main_osc_ready;
    logic pll_lock_raw;
    logic master_clk_ready;
    logic [2:0] prog_clk_ready;
    logic main_select_done;
  } crsi_ready_t;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } crsi_aphase_t;
endpackage

// [hw/crsi_sync.sv]
// Purpose: Two flip-flop synchroniser for a vector of levels
// Assumes: Inputs come from another clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module crsi_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } crsi_sync_st_t;
  crsi_sync_st_t st_r;
  crsi_sync_st_t st_nxt;

  // Shift through two stages
  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.s2;
endmodule

// [hw/crsi_settle.sv]
// Purpose: Counts slow clock ticks after a PLL configuration write
// Assumes: slow_tick is a one-cycle pulse on clk_sys per slow clock period
// Notes: Lock qualification holds low until the count has expired
`timescale 1ns/1ps
module crsi_settle
  import crsi_pkg::*;
(
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Control
  input wire logic cfg_write,
  input wire logic [CRSI_PLL_CNT_W-1:0] settle_count,
  input wire logic slow_tick,
  // Result
  output logic settled
);
  typedef struct packed {
    logic [CRSI_SETTLE_W-1:0] remain;
    logic done;
  } crsi_settle_st_t;
  crsi_settle_st_t st_r;
  crsi_settle_st_t st_nxt;

  // Reload on each write; a zero count settles at once
  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      if (cfg_write)
      begin
        st_nxt.remain = CRSI_SETTLE_W'({3'b000, settle_count} * CRSI_SETTLE_MULT);
        st_nxt.done = (settle_count == '0);
      end
      else if (!st_r.done && slow_tick)
      begin
        if (st_r.remain <= CRSI_SETTLE_W'(1))
        begin
          st_nxt.remain = '0;
          st_nxt.done = 1'b1;
        end
        else
          st_nxt.remain = st_r.remain - CRSI_SETTLE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= '{remain: '0, done: 1'b1};
    else
      st_r <= st_nxt;
  end

  assign settled = st_r.done;

  // Done never rises while count remains
  // A fresh configuration write may legally settle at once, so it is left out
  settle_early_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.remain > CRSI_SETTLE_W'(1) && !cfg_write) |=> !$rose(st_r.done))
    else $error("settle finished early");
endmodule

// [hw/crsi_top.sv]
// Purpose: Clock readiness status, interrupt masking and wake-up enables
// Assumes: AHB-Lite slave, single word transfers, always OKAY
// Notes: Readiness inputs are asynchronous and are synchronised here
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

// Contract
// - Writing one to disable register turns the source off; zero leaves it.
// - Sources sit at bits 0, 1, 3 and 8 to 10.
// - Writing one to enable register turns the source on; zero no effect.
// - Mask view is read-only; a bit reads 0 when enabled, 1 when disabled.
// - Status bit 0 shows main clock ready.
// - Status bit 1 shows PLL lock.
// - Lock waits eight times the settle count in slow clocks after config write.
// - Status bit 3 shows master clock ready.
// - Status bits 8 to 10 show programmable clocks 0 to 2 ready.
// - Status bit 16 reads 0 during selection and after reset, 1 when done.
// - Sixteen read-write wake enables gate the wake inputs into a restart request.
// - Status and mask read-only; disable register is write-only, reads zero.
module crsi_top
  import crsi_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Readiness inputs from oscillator, PLL and switch logic
  input wire crsi_pkg::crsi_ready_t ready_in,
  input wire logic slow_clk_in,
  // Wake-up inputs
  input wire logic [15:0] wake_in,
  // Outputs
  output logic irq,
  output logic fast_restart
);
  import crsi_pkg::*;

  typedef struct packed {
    crsi_aphase_t ap;
    logic [31:0] imr;
    logic [15:0] wake_en;
    logic [CRSI_PLL_CNT_W-1:0] settle_count;
    logic cfg_wr;
    logic slow_prev;
    logic [31:0] rdata;
    logic irq;
    logic fast;
  } crsi_st_t;

  crsi_st_t st_r;
  crsi_st_t st_nxt;
  crsi_ready_t rdy_s;
  logic slow_s;
  logic [15:0] wake_s;
  logic settled;
  logic [31:0] status_w;
  logic [31:0] mask_view_w;

  // Readiness levels cross in through two flops
  crsi_sync #(.W($bits(crsi_ready_t))) u_rdy_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(ready_in),
    .sync_out(rdy_s)
  );

  // Slow clock and wake pins share one synchroniser
  crsi_sync #(.W(17)) u_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .async_in({slow_clk_in, wake_in}),
    .sync_out({slow_s, wake_s})
  );

  // Settle counter qualifies the raw lock after each configuration write
  crsi_settle u_settle (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .cfg_write(st_r.cfg_wr),
    .settle_count(st_r.settle_count),
    .slow_tick(slow_s && !st_r.slow_prev),
    .settled(settled)
  );

  // Status word assembled from synchronised inputs
  always_comb
  begin
    status_w = CRSI_RST_ZERO;
    status_w[CRSI_BIT_MAIN] = rdy_s.main_osc_ready;
    status_w[CRSI_BIT_LOCK] = rdy_s.pll_lock_raw && settled;
    status_w[CRSI_BIT_MCK] = rdy_s.master_clk_ready;
    status_w[CRSI_BIT_PCK0 +: CRSI_NUM_PCK] = rdy_s.prog_clk_ready;
    status_w[CRSI_BIT_SELS] = rdy_s.main_select_done;
  end

  // Stored bit is the enable; the view is inverted, limited to defined sources
  assign mask_view_w = ~st_r.imr & CRSI_IRQ_BITS;

  // Bus handling and register updates
  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      st_nxt.cfg_wr = 1'b0;
      st_nxt.slow_prev = slow_s;
      // Data phase of a write completes with zero wait states
      if (st_r.ap.valid && st_r.ap.write)
      begin
        unique case (st_r.ap.addr)
          CRSI_OFF_IRQ_ENABLE: st_nxt.imr = st_r.imr | (hwdata & CRSI_IRQ_BITS);
          CRSI_OFF_IRQ_DISABLE: st_nxt.imr = st_r.imr & ~(hwdata & CRSI_IRQ_BITS);
          CRSI_OFF_WAKEUP_ENABLE: st_nxt.wake_en = hwdata[15:0];
          CRSI_OFF_PLL_CONFIG:
          begin
            st_nxt.settle_count = hwdata[CRSI_PLL_CNT_LSB +: CRSI_PLL_CNT_W];
            st_nxt.cfg_wr = 1'b1;
          end
          default: st_nxt.imr = st_r.imr; // Read-only or unmapped writes ignored
        endcase
      end
      // Address phase capture
      if (hready)
      begin
        st_nxt.ap.valid = hsel && htrans[1];
        st_nxt.ap.write = hwrite;
        st_nxt.ap.addr = haddr[7:0];
        // Read data prepared for the following data phase
        // It comes from the state before this edge, so a read that follows a write
        // straight away still returns the old contents; masters leave one idle cycle
        st_nxt.rdata = CRSI_RST_ZERO;
        if (hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h000000)
        begin
          unique case (haddr[7:0])
            CRSI_OFF_IRQ_MASK_VIEW: st_nxt.rdata = mask_view_w;
            CRSI_OFF_CLOCK_STATUS: st_nxt.rdata = status_w;
            CRSI_OFF_WAKEUP_ENABLE: st_nxt.rdata = {16'h0000, st_r.wake_en};
            CRSI_OFF_PLL_CONFIG:
              st_nxt.rdata = {16'h0000, 2'b00, st_r.settle_count, 8'h00};
            default: st_nxt.rdata = CRSI_RST_ZERO; // Write-only and unmapped read zero
          endcase
        end
        if (haddr[31:8] != 24'h000000)
          st_nxt.ap.valid = 1'b0;
      end
      // Combined request from enabled, set sources
      st_nxt.irq = |(status_w & st_r.imr & CRSI_IRQ_BITS);
      // Enabled wake input raises the restart request
      st_nxt.fast = |(wake_s & st_r.wake_en);
    end
  end

  // State register; reset loads every field with a constant
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r.ap <= '0;
      st_r.imr <= CRSI_RST_ZERO;
      st_r.wake_en <= CRSI_RST_WAKE;
      st_r.settle_count <= '0;
      st_r.cfg_wr <= 1'b0;
      st_r.slow_prev <= 1'b0;
      st_r.rdata <= CRSI_RST_ZERO;
      st_r.irq <= 1'b0;
      st_r.fast <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Zero wait state slave, hready out held high
  always_ff @(posedge clk_sys)
  begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
  end

  // Outputs come straight from the state register
  assign hrdata = st_r.rdata;
  assign irq = st_r.irq;
  assign fast_restart = st_r.fast;

  // Disable write clears addressed source next cycle
  disable_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write && st_r.ap.addr == CRSI_OFF_IRQ_DISABLE)
    |=> ((st_r.imr & $past(hwdata) & CRSI_IRQ_BITS) == 32'h0))
    else $error("disable did not clear source");

  // Zeros written to the disable register leave other sources alone
  disable_keeps_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write && st_r.ap.addr == CRSI_OFF_IRQ_DISABLE)
    |=> ((st_r.imr & ~$past(hwdata)) == ($past(st_r.imr) & ~$past(hwdata))))
    else $error("disable touched an unselected source");

  // Enable write sets addressed sources
  enable_sets_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write && st_r.ap.addr == CRSI_OFF_IRQ_ENABLE)
    |=> ((st_r.imr & $past(hwdata) & CRSI_IRQ_BITS) == ($past(hwdata) & CRSI_IRQ_BITS)))
    else $error("enable did not set source");

  // Zeros written to the enable register leave other sources alone
  enable_keeps_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write && st_r.ap.addr == CRSI_OFF_IRQ_ENABLE)
    |=> ((st_r.imr & ~$past(hwdata)) == ($past(st_r.imr) & ~$past(hwdata))))
    else $error("enable touched an unselected source");

  // Undefined enable bits never stored
  undef_bits_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.imr & ~CRSI_IRQ_BITS) == 32'h0)
    else $error("undefined mask bit set");

  // Writes to read-only registers change no stored setting
  ro_write_keeps_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write
     && (st_r.ap.addr == CRSI_OFF_IRQ_MASK_VIEW || st_r.ap.addr == CRSI_OFF_CLOCK_STATUS))
    |=> ($stable(st_r.imr) && $stable(st_r.wake_en)))
    else $error("read-only write changed state");

  // Mask view read returns inverse of enables
  mask_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_IRQ_MASK_VIEW})
    |=> (hrdata == (~$past(st_r.imr) & CRSI_IRQ_BITS)))
    else $error("mask view wrong");

  // Interrupt follows enabled status
  irq_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en |=> (irq == |($past(status_w) & $past(st_r.imr))))
    else $error("irq mismatch");

  // No enabled source means no request one cycle later
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && (st_r.imr & CRSI_IRQ_BITS) == 32'h0) |=> !irq)
    else $error("irq raised with every source disabled");

  // A configuration write with a nonzero count restarts the settle wait
  lock_gated_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.cfg_wr && st_r.settle_count != '0)
    |=> (!settled && !status_w[CRSI_BIT_LOCK]))
    else $error("lock shown before settle");

  // Lock bit reads raw lock qualified by the settle counter
  lock_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_CLOCK_STATUS})
    |=> (hrdata[CRSI_BIT_LOCK] == $past(rdy_s.pll_lock_raw && settled)))
    else $error("lock status wrong");

  // Wake request follows enables
  wake_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    clk_en |=> (fast_restart == |($past(wake_s) & $past(st_r.wake_en))))
    else $error("fast restart mismatch");

  // Wake enable write stores the low half word
  wake_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && st_r.ap.valid && st_r.ap.write && st_r.ap.addr == CRSI_OFF_WAKEUP_ENABLE)
    |=> (st_r.wake_en == $past(hwdata[15:0])))
    else $error("wake enable not stored");

  // Wake enable reads back with the upper half zero
  wake_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_WAKEUP_ENABLE})
    |=> (hrdata == {16'h0000, $past(st_r.wake_en)}))
    else $error("wake enable read wrong");

  // Status read shows selection and main clock ready bits
  status_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_CLOCK_STATUS})
    |=> (hrdata[CRSI_BIT_SELS] == $past(rdy_s.main_select_done)
         && hrdata[CRSI_BIT_MAIN] == $past(rdy_s.main_osc_ready)))
    else $error("status read wrong");

  // Master and programmable clock bits follow their inputs
  status_clock_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_CLOCK_STATUS})
    |=> (hrdata[CRSI_BIT_MCK] == $past(rdy_s.master_clk_ready)
         && hrdata[CRSI_BIT_PCK0 +: CRSI_NUM_PCK] == $past(rdy_s.prog_clk_ready)))
    else $error("clock ready bits wrong");

  // Bits with no function read zero in the status word
  status_undef_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_CLOCK_STATUS})
    |=> ((hrdata & ~(CRSI_IRQ_BITS | (32'h1 << CRSI_BIT_SELS))) == 32'h0))
    else $error("undefined status bit set");

  // Disable register reads as zero
  disable_reads_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && hready && hsel && htrans[1] && !hwrite && haddr == {24'h0, CRSI_OFF_IRQ_DISABLE})
    |=> (hrdata == 32'h0))
    else $error("write-only reg read nonzero");
endmodule

// [tb/crsi_top_tb.sv]
// Purpose: Self-checking bench for the clock ready status block
// Assumes: Zero wait AHB-Lite slave, readiness seen 2-3 cycles late
// Notes: Mask view reads 1 for a disabled source
`timescale 1ns/1ps
module crsi_top_tb;
  import crsi_pkg::*;
  logic clk_sys, srst, clk_en, hsel, hwrite, hready, hreadyout, hresp, irq, fast_restart, slow_clk_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] wake_in;
  crsi_ready_t ready_in;
  int bad_count = 0;
  int n_compared = 0;
  // Status image for ready_in bit i set alone
  logic [31:0] st_exp [7] = '{32'h10000, 32'h100, 32'h200, 32'h400, 32'h8, 32'h2, 32'h1};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  crsi_top u_crsi_top (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ready_in(ready_in),
    .slow_clk_in(slow_clk_in), .wake_in(wake_in), .irq(irq), .fast_restart(fast_restart));

  // 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One word transfer; waits on hready with a bound, never on a fixed count
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 40);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 80);
    rd = hrdata;
    if (hready !== 1'b1 || hresp !== 1'b0)
    begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Idle edge first: read data is captured after a preceding write lands
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    cyc(1);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task t_reset;
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h0000_070b);
    rchk(CRSI_OFF_CLOCK_STATUS, 32'h0);
    rchk(CRSI_OFF_WAKEUP_ENABLE, 32'h0);
    rchk(8'h20, 32'h0);
  endtask

  // Set and clear through the two write-only registers
  task t_masks;
    xfer(CRSI_OFF_IRQ_ENABLE, 1'b1, 32'hffff_ffff);
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h0);
    xfer(CRSI_OFF_IRQ_DISABLE, 1'b1, 32'h1);
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h1);
    xfer(CRSI_OFF_IRQ_DISABLE, 1'b1, 32'h0);
    xfer(CRSI_OFF_IRQ_ENABLE, 1'b1, 32'h0);
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h1);
    xfer(CRSI_OFF_IRQ_MASK_VIEW, 1'b1, 32'h0);
    xfer(CRSI_OFF_CLOCK_STATUS, 1'b1, 32'hffff_ffff);
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h1);
    rchk(CRSI_OFF_IRQ_DISABLE, 32'h0);
  endtask

  // Walk one readiness input at a time; main ready alone stays masked
  task t_status;
    for (int i = 0; i < 7; i++)
    begin
      ready_in <= 7'(1 << i);
      cyc(5);
      rchk(CRSI_OFF_CLOCK_STATUS, st_exp[i]);
      chk({31'h0, irq}, {31'h0, |(st_exp[i] & 32'h0000_070a)});
    end
    ready_in <= '1;
    cyc(5);
    rchk(CRSI_OFF_CLOCK_STATUS, 32'h0001_070b);
    xfer(CRSI_OFF_IRQ_DISABLE, 1'b1, 32'hffff_ffff);
    cyc(5);
    chk({31'h0, irq}, 32'h0);
    rchk(CRSI_OFF_IRQ_MASK_VIEW, 32'h0000_070b);
  endtask

  task wchk(input logic [15:0] v, input logic e);
    wake_in <= v;
    cyc(5);
    chk({31'h0, fast_restart}, {31'h0, e});
  endtask

  task t_wake;
    xfer(CRSI_OFF_WAKEUP_ENABLE, 1'b1, 32'hffff_8001);
    rchk(CRSI_OFF_WAKEUP_ENABLE, 32'h0000_8001);
    wchk(16'h0001, 1'b1);
    wchk(16'h0002, 1'b0);
    wchk(16'h8000, 1'b1);
    wchk(16'h7ffe, 1'b0);
  endtask

  // Count of 2 holds lock low for 16 slow edges
  task t_settle;
    ready_in <= 7'h20;
    xfer(CRSI_OFF_PLL_CONFIG, 1'b1, 32'h0000_0200);
    rchk(CRSI_OFF_PLL_CONFIG, 32'h0000_0200);
    for (int k = 1; k <= 16; k++)
    begin
      slow_clk_in <= 1'b1;
      cyc(4);
      slow_clk_in <= 1'b0;
      cyc(4);
      if (k == 15)
        rchk(CRSI_OFF_CLOCK_STATUS, 32'h0);
    end
    cyc(4);
    rchk(CRSI_OFF_CLOCK_STATUS, 32'h2);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    srst = 1'b1;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ready_in = '0;
    slow_clk_in = 1'b0;
    wake_in = 16'h0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_masks();
    t_status();
    t_wake();
    t_settle();
    end_of_test();
  end
endmodule
